// *** logic/sadc_pkg.sv ***
// Shared constants and types of the converter control block
package sadc_pkg;
   // Data path widths
   localparam int RES_W    = 16;
   localparam int BYTE_W   = 8;
   localparam int CHAN_W   = 2;
   localparam int NUM_CHAN = 4;
   localparam int DIV_W    = 2;
   localparam int DCNT_W   = 3;
   localparam int CNT_W    = 5;
   // Conversion clock rising edges from start to end of conversion
   localparam int CLK_EDGES_PER_CVT = 18;

   // Register bus layout
   localparam int        ADDR_W       = 8;
   localparam int        DATA_W       = 32;
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_RESULT   = 8'h08;
   localparam logic [7:0] OFS_INT_STAT = 8'h0C;
   localparam logic [7:0] OFS_INT_MASK = 8'h10;

   // Field positions and reset values
   localparam int         CTRL_EN_BIT    = 0;
   localparam logic       CTRL_EN_RESET  = 1'b1;
   localparam int         STAT_BUSY_BIT  = 0;
   localparam int         STAT_CHAN_LSB  = 4;
   localparam int         STAT_DIV_LSB   = 8;
   localparam int         INT_W          = 2;
   localparam int         INT_DONE_BIT   = 0;
   localparam int         INT_RDBUSY_BIT = 1;
   localparam logic [1:0] INT_MASK_RESET = 2'h0;

   // Conversion sequencer states, one-hot
   typedef enum logic [1:0] {
      SADC_IDLE    = 2'b01,
      SADC_CONVERT = 2'b10
   } sadc_state_t;
endpackage : sadc_pkg

// *** logic/sadc_core_if.sv ***
// Signals shared between the sequencer, clock divider and register file
`timescale 1ns/1ns
interface sadc_core_if;
   logic                          ext_rise;
   logic [sadc_pkg::DIV_W-1:0]    div_code;
   logic                          restart;
   logic                          slow_tick;
   logic                          busy;
   logic                          done;
   logic                          rd_busy;
   logic [sadc_pkg::RES_W-1:0]    result;
   logic [sadc_pkg::CHAN_W-1:0]   chan;
   logic                          enable;

   modport core (output ext_rise, div_code, restart, busy, done, rd_busy,
                 result, chan, input slow_tick, enable);
   modport div  (input ext_rise, div_code, restart, output slow_tick);
   modport regs (input busy, done, rd_busy, result, chan, div_code,
                 output enable);
endinterface : sadc_core_if

// *** logic/sadc_clkdiv.sv ***
// Divides external clock rising edges into conversion clock ticks
`timescale 1ns/1ns
module sadc_clkdiv (
   input  wire logic sys_clk_i,
   input  wire logic sys_rst_i,
   sadc_core_if.div  core
);
   logic [sadc_pkg::DCNT_W-1:0] cnt;
   logic [sadc_pkg::DCNT_W-1:0] rises;
   logic [sadc_pkg::DIV_W-1:0]  code_prev;
   wire  [sadc_pkg::DCNT_W-1:0] div_limit;
   wire                         wrap;
   wire                         code_chg;

   // Code 0,1,2,3 gives limit 0,1,3,7: divide by 1,2,4,8
   assign div_limit = {core.div_code == 2'h3, core.div_code[1],
                       |core.div_code};
   assign wrap      = core.ext_rise & (cnt == div_limit);
   // A new code restarts the count, else a count above the new limit
   // would run up to eight rises before the first tick
   assign code_chg  = core.div_code != code_prev;
   // Restart aligns the divided clock to the start of conversion
   assign core.slow_tick = wrap & ~core.restart & ~code_chg;

   // Divider code history
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         code_prev <= 2'h0;
      end else begin
         code_prev <= core.div_code;
      end
   end

   // Edge counter
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || core.restart || code_chg || wrap) begin
         cnt <= 3'h0;
      end else if (core.ext_rise) begin
         cnt <= cnt + 3'h1;
      end
   end

   // Helper for checking: rises seen since last tick
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || core.restart || code_chg || core.slow_tick) begin
         rises <= 3'h0;
      end else if (core.ext_rise) begin
         rises <= rises + 3'h1;
      end
   end

   a_div_ratio: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      core.slow_tick |-> rises == div_limit)
      else $error("tick spacing differs from divider code");
   a_div_code: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      core.div_code == 2'h0 && $stable(core.div_code) && core.ext_rise
      && !core.restart
      |-> core.slow_tick)
      else $error("divide by one missed an edge");
endmodule : sadc_clkdiv

// *** logic/sadc_regs.sv ***
// APB register file with sticky interrupt status
`timescale 1ns/1ns
module sadc_regs (
   input  wire logic                          sys_clk_i,
   input  wire logic                          sys_rst_i,
   input  wire logic                          psel_i,
   input  wire logic                          penable_i,
   input  wire logic                          pwrite_i,
   input  wire logic [sadc_pkg::ADDR_W-1:0]   paddr_i,
   input  wire logic [sadc_pkg::DATA_W-1:0]   pwdata_i,
   output logic      [sadc_pkg::DATA_W-1:0]   prdata_o,
   output wire logic                          pready_o,
   output wire logic                          pslverr_o,
   output wire logic                          irq_o,
   sadc_core_if.regs                          core
);
   logic                        en;
   logic [sadc_pkg::INT_W-1:0]  int_stat;
   logic [sadc_pkg::INT_W-1:0]  int_mask;
   wire                         hit;
   wire                         wr;
   wire                         setup;
   wire [sadc_pkg::INT_W-1:0]   set_bits;
   wire [sadc_pkg::DATA_W-1:0]  rd_mux;

   // Address decode and strobes
   assign hit   = paddr_i == sadc_pkg::OFS_CTRL
               || paddr_i == sadc_pkg::OFS_STATUS
               || paddr_i == sadc_pkg::OFS_RESULT
               || paddr_i == sadc_pkg::OFS_INT_STAT
               || paddr_i == sadc_pkg::OFS_INT_MASK;
   assign setup     = psel_i & ~penable_i;
   assign wr        = psel_i & penable_i & pwrite_i & hit;
   // Read data is latched in setup, so access completes at once
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;
   assign set_bits  = {core.rd_busy, core.done};
   assign irq_o     = |(int_stat & int_mask);
   assign core.enable = en;

   // Read selection; unmapped reads return zero
   assign rd_mux =
      (paddr_i == sadc_pkg::OFS_CTRL)     ? 32'(en) :
      (paddr_i == sadc_pkg::OFS_STATUS)   ?
         32'({core.div_code, 2'h0, core.chan, 3'h0, core.busy}) :
      (paddr_i == sadc_pkg::OFS_RESULT)   ? 32'(core.result) :
      (paddr_i == sadc_pkg::OFS_INT_STAT) ? 32'(int_stat) :
      (paddr_i == sadc_pkg::OFS_INT_MASK) ? 32'(int_mask) : 32'h0000_0000;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (setup && !pwrite_i) begin
         prdata_o <= rd_mux;
      end
   end

   // Control and mask registers
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         en       <= sadc_pkg::CTRL_EN_RESET;
         int_mask <= sadc_pkg::INT_MASK_RESET;
      end else if (wr && paddr_i == sadc_pkg::OFS_CTRL) begin
         en <= pwdata_i[sadc_pkg::CTRL_EN_BIT];
      end else if (wr && paddr_i == sadc_pkg::OFS_INT_MASK) begin
         int_mask <= pwdata_i[sadc_pkg::INT_W-1:0];
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         int_stat <= 2'h0;
      end else if (wr && paddr_i == sadc_pkg::OFS_INT_STAT) begin
         int_stat <= (int_stat & ~pwdata_i[sadc_pkg::INT_W-1:0]) | set_bits;
      end else begin
         int_stat <= int_stat | set_bits;
      end
   end

   a_read_busy_flag: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      core.rd_busy |=> int_stat[sadc_pkg::INT_RDBUSY_BIT])
      else $error("read during conversion not flagged");
   a_irq_level: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      core.done && int_mask[sadc_pkg::INT_DONE_BIT] |=> irq_o)
      else $error("interrupt missing after conversion end");
endmodule : sadc_regs

// *** logic/sadc_top.sv ***
// Converter control: strobe handling, sequencing and three-state readout
//
// Overview of operation
// - Data lines stay undriven for the whole of every conversion.
// - Chip select and read strobe are active low on both sides.
// - Conversion clock is the external clock divided by 1, 2, 4 or 8.
// - Falling convert strobe enters hold at once, no external clock needed.
// - Channel address is captured on convert strobe rising edge for next use.
// - Channel index 0 to 3 picks analog input 0 to 3 against common.
// - Busy is high during conversion and low once result is readable.
// - Conversion ends after the eighteenth conversion clock rising edge.
// - Bus width select high gives 8-bit bus, low gives 16-bit bus.
// - In 16-bit mode result bits 15..0 appear on lines 15..0.
// - In 8-bit mode result bits 15..8 appear on lines 7..0.
// - Bus width select acts asynchronously, remapping without a clock edge.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module sadc_top #(
   parameter int N_EDGES = sadc_pkg::CLK_EDGES_PER_CVT
) (
   input  wire logic                          sys_clk_i,
   input  wire logic                          sys_rst_i,
   input  wire logic                          ext_clk_i,
   input  wire logic [sadc_pkg::DIV_W-1:0]    clock_divider_select_i,
   input  wire logic                          convert_strobe_n_i,
   input  wire logic                          channel_select_lsb_i,
   input  wire logic                          channel_select_msb_i,
   input  wire logic                          chip_select_n_i,
   input  wire logic                          read_strobe_n_i,
   input  wire logic                          bus_width_byte_i,
   input  wire logic [sadc_pkg::RES_W-1:0]    sar_result_i,
   output wire logic [sadc_pkg::RES_W-1:0]    output_data_lines_o,
   output wire logic [sadc_pkg::RES_W-1:0]    output_data_lines_oe_o,
   output wire logic                          busy_o,
   output wire logic                          hold_o,
   output wire logic [sadc_pkg::NUM_CHAN-1:0] mux_sel_o,
   input  wire logic                          psel_i,
   input  wire logic                          penable_i,
   input  wire logic                          pwrite_i,
   input  wire logic [sadc_pkg::ADDR_W-1:0]   paddr_i,
   input  wire logic [sadc_pkg::DATA_W-1:0]   pwdata_i,
   output wire logic [sadc_pkg::DATA_W-1:0]   prdata_o,
   output wire logic                          pready_o,
   output wire logic                          pslverr_o,
   output wire logic                          irq_o
);
   // Counter must reach the end count without wrapping
   if (N_EDGES < 2 || N_EDGES > 31) begin : g_bad_edges
      $error("N_EDGES must lie between 2 and 31");
   end

   localparam logic [sadc_pkg::CNT_W-1:0] LAST_TICK =
      sadc_pkg::CNT_W'(N_EDGES - 1);

   sadc_core_if core ();

   sadc_pkg::sadc_state_t             state;
   sadc_pkg::sadc_state_t             next_state;
   logic                              strobe_prev;
   logic                              ext_prev;
   logic [sadc_pkg::CNT_W-1:0]        tick_cnt;
   logic [sadc_pkg::RES_W-1:0]        result;
   logic [sadc_pkg::CHAN_W-1:0]       chan;
   logic [sadc_pkg::CNT_W-1:0]        chk_ticks;

   wire                               strobe_fall;
   wire                               strobe_rise;
   wire                               start;
   wire                               finish;
   wire                               converting;
   wire                               read_active;
   wire [sadc_pkg::RES_W-1:0]         byte_view;
   wire [sadc_pkg::CHAN_W-1:0]        addr_in;

   // Edge detection on pins already synchronous to the system clock
   assign strobe_fall = strobe_prev & ~convert_strobe_n_i;
   assign strobe_rise = ~strobe_prev & convert_strobe_n_i;
   assign core.ext_rise = ext_clk_i & ~ext_prev;
   assign addr_in = {channel_select_msb_i, channel_select_lsb_i};

   // Start only from idle and while software enables the block;
   // a strobe fall during a conversion is ignored
   assign start  = (state == sadc_pkg::SADC_IDLE) & strobe_fall
                 & core.enable;
   assign finish = (state == sadc_pkg::SADC_CONVERT) & core.slow_tick
                 & (tick_cnt == LAST_TICK);
   assign converting = state == sadc_pkg::SADC_CONVERT;

   // Hold follows the strobe edge in the same cycle, not a clock edge
   assign hold_o = converting | start;
   assign busy_o = converting;

   // Divider and register file hookup
   assign core.div_code = clock_divider_select_i;
   assign core.restart  = start;
   assign core.busy     = converting;
   assign core.done     = finish;
   assign core.result   = result;
   assign core.chan     = chan;

   // Active-low select and read; the start cycle blanks the bus too
   assign read_active = ~chip_select_n_i & ~read_strobe_n_i
                      & ~converting & ~start;
   // A read attempt while converting is host misuse; flag it
   assign core.rd_busy = ~chip_select_n_i & ~read_strobe_n_i
                       & converting;

   // Byte lane mapping is purely combinational on the width pin
   assign byte_view = {8'h00, result[15:8]};
   assign output_data_lines_o = bus_width_byte_i ? byte_view
                                                 : result;
   assign output_data_lines_oe_o = !read_active ? 16'h0000
                                 : bus_width_byte_i ? 16'h00FF
                                 : 16'hFFFF;

   // One-hot multiplexer select per analog input
   for (genvar i = 0; i < sadc_pkg::NUM_CHAN; i++) begin : g_mux
      assign mux_sel_o[i] = chan == sadc_pkg::CHAN_W'(i);
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         sadc_pkg::SADC_IDLE: begin
            if (start) begin
               next_state = sadc_pkg::SADC_CONVERT;
            end
         end
         sadc_pkg::SADC_CONVERT: begin
            if (finish) begin
               next_state = sadc_pkg::SADC_IDLE;
            end
         end
         default: begin
            next_state = sadc_pkg::SADC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state <= sadc_pkg::SADC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Pin history; strobe idles high so reset does not fake an edge
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         strobe_prev <= 1'b1;
         ext_prev    <= 1'b0;
      end else begin
         strobe_prev <= convert_strobe_n_i;
         ext_prev    <= ext_clk_i;
      end
   end

   // Conversion clock edges since start
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || start) begin
         tick_cnt <= 5'h00;
      end else if (converting && core.slow_tick) begin
         tick_cnt <= tick_cnt + 5'h01;
      end
   end

   // Address latched on the strobe rising edge, used next conversion
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         chan <= 2'h0;
      end else if (strobe_rise) begin
         chan <= addr_in;
      end
   end

   // Result becomes visible only once the conversion is complete
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         result <= 16'h0000;
      end else if (finish) begin
         result <= sar_result_i;
      end
   end

   // Helper for checking: ticks counted during the busy window
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || start) begin
         chk_ticks <= 5'h00;
      end else if (converting && core.slow_tick) begin
         chk_ticks <= chk_ticks + 5'h01;
      end
   end

   sadc_clkdiv u_clkdiv (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .core      (core)
   );

   sadc_regs u_regs (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .paddr_i   (paddr_i),
      .pwdata_i  (pwdata_i),
      .prdata_o  (prdata_o),
      .pready_o  (pready_o),
      .pslverr_o (pslverr_o),
      .irq_o     (irq_o),
      .core      (core)
   );

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_bus_quiet_busy: assert property (busy_o |->
      output_data_lines_oe_o == 16'h0000)
      else $error("data lines driven during conversion");
   a_strobes_low: assert property (|output_data_lines_oe_o |->
      !chip_select_n_i && !read_strobe_n_i)
      else $error("bus driven without both strobes low");
   a_hold_at_once: assert property (
      $fell(convert_strobe_n_i) && !busy_o && core.enable |-> hold_o)
      else $error("hold not entered on strobe fall");
   a_addr_latch: assert property ($rose(convert_strobe_n_i) |=>
      chan == $past(addr_in))
      else $error("channel address not captured on strobe rise");
   a_mux_onehot: assert property (
      mux_sel_o == (4'h1 << chan) && $onehot(mux_sel_o))
      else $error("analog select does not match channel");
   a_busy_span: assert property (start |=> busy_o [*2])
      else $error("busy did not rise after start");
   a_end_count: assert property ($fell(busy_o) |->
      chk_ticks == sadc_pkg::CNT_W'(N_EDGES) && $past(core.slow_tick))
      else $error("conversion ended on wrong clock edge");
   a_wide_map: assert property (!bus_width_byte_i && read_active |->
      output_data_lines_o == result && output_data_lines_oe_o == 16'hFFFF)
      else $error("16-bit mapping wrong");
   a_byte_map: assert property (bus_width_byte_i && read_active |->
      output_data_lines_o[7:0] == result[15:8]
      && output_data_lines_oe_o == 16'h00FF)
      else $error("8-bit mapping wrong");
   a_width_async: assert property (
      $changed(bus_width_byte_i) && read_active |->
      output_data_lines_oe_o[8] == !bus_width_byte_i)
      else $error("width change not applied in same cycle");

   c_full_cvt: cover property (start ##[1:300] $fell(busy_o));
   c_byte_swap: cover property (read_active && bus_width_byte_i
      ##1 read_active && !bus_width_byte_i);
   c_read_busy: cover property (core.rd_busy);
endmodule : sadc_top

// *** testbench/sadc_host_model.sv ***
// Host processor model driving the converter's strobe and readout pins
`timescale 1ns/1ns
module sadc_host_model (
   input  wire logic       clk_i,
   output logic            convert_strobe_n_n_o,
   output logic            cs_n_o,
   output logic            rd_n_o,
   output logic            a_lsb_o,
   output logic            a_msb_o,
   output logic            width_o,
   output logic [1:0]      div_o
);
   // Idle host: strobes released, 16-bit bus, divide by one
   initial begin
      convert_strobe_n_n_o = 1'b1;
      cs_n_o   = 1'b1; // Active low select idles high
      rd_n_o   = 1'b1; // Active low read idles high
      a_lsb_o  = 1'b0;
      a_msb_o  = 1'b0;
      width_o  = 1'b0;
      div_o    = 2'h0;
   end

   // Strobe pulse; address is set up before the rising edge of the strobe
   task convert(input logic [1:0] chan, input logic [1:0] code);
      @(posedge clk_i);
      div_o    <= code;
      a_msb_o  <= chan[1];
      a_lsb_o  <= chan[0];
      cs_n_o   <= 1'b1; // Select released at the same clock edge as the strobe falls
      convert_strobe_n_n_o <= 1'b0;
      @(posedge clk_i);
      convert_strobe_n_n_o <= 1'b1;
   endtask : convert

   // Readout; caller waits for busy low, except when a refusal is wanted
   task read(input logic both);
      @(posedge clk_i);
      cs_n_o  <= 1'b0; // Select at the next clock edge; the task does not wait for busy low
      rd_n_o  <= 1'b0;
      width_o <= 1'b0;
      if (both) begin
         @(posedge clk_i);
         width_o <= 1'b1; // Upper half fetched under the same strobe
      end
      @(posedge clk_i);
      rd_n_o  <= 1'b1;
      cs_n_o  <= 1'b1;
      width_o <= 1'b0;
   endtask : read
endmodule : sadc_host_model

// *** testbench/sar_adc_parallel_host_interface_test.sv ***
// Self-checking bench of the converter control block
`timescale 1ns/1ns
module sar_adc_parallel_host_interface_test;
   localparam int NE = 4; // Shortened conversion length keeps the run brief
   logic        sys_clk_i = 1'b0;
   logic        sys_rst_i;
   logic        ext_clk;
   logic        psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, exp;
   logic        pready, pslverr, irq, busy, hold, err;
   logic        convert_strobe_n_n, cs_n, rd_n, a_lsb, a_msb, width;
   logic [1:0]  div;
   logic [15:0] res, data, oe;
   logic [3:0]  mux;
   logic [31:0] q_apb[$], q_bus[$];
   int          error_cnt = 0, check_count = 0, seed = 32'h2986, n;

   sadc_top #(.N_EDGES(NE)) u_sadc_top (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ext_clk_i(ext_clk),
      .clock_divider_select_i(div), .convert_strobe_n_i(convert_strobe_n_n),
      .channel_select_lsb_i(a_lsb), .channel_select_msb_i(a_msb),
      .chip_select_n_i(cs_n), .read_strobe_n_i(rd_n),
      .bus_width_byte_i(width), .sar_result_i(res),
      .output_data_lines_o(data), .output_data_lines_oe_o(oe),
      .busy_o(busy), .hold_o(hold), .mux_sel_o(mux), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .irq_o(irq));

   sadc_host_model u_sadc_host_model (
      .clk_i(sys_clk_i), .convert_strobe_n_n_o(convert_strobe_n_n), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .a_lsb_o(a_lsb), .a_msb_o(a_msb), .width_o(width), .div_o(div));

   // Clock and a free running external converter clock at half the rate
   always #25 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) ext_clk <= sys_rst_i ? 1'b0 : ~ext_clk;

   task compare(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : compare

   task end_of_test;
      if (error_cnt == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   // APB master; waits for pready, bounded by the watchdog
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do @(posedge sys_clk_i); while (pready !== 1'b1);
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   // Result watcher: pops the oldest note on each APB read and each host bus read cycle
   always @(posedge sys_clk_i) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         exp = q_apb.size() ? q_apb.pop_front() : {32{1'bx}};
         compare(prdata, exp);
      end
      if (rd_n === 1'b0 && cs_n === 1'b0) begin
         exp = q_bus.size() ? q_bus.pop_front() : {32{1'bx}};
         compare({oe, data & oe}, exp);
      end
   end

   // Hang guard, well beyond the expected few hundred cycles
   initial begin
      #(50 * 20000);
      error_cnt++;
      end_of_test();
   end

   initial begin
      sys_rst_i <= 1'b1;
      psel      <= 1'b0;
      penable   <= 1'b0;
      pwrite    <= 1'b0;
      paddr     <= 8'h00;
      pwdata    <= 32'h0;
      res       <= 16'h0;
      repeat (10) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      #1 compare({busy, hold, irq, mux}, {3'b000, 4'b0001});
      q_apb.push_back(32'h1);
      apb(1'b0, sadc_pkg::OFS_CTRL, 32'h0);
      q_apb.push_back(32'h0);
      apb(1'b0, sadc_pkg::OFS_INT_MASK, 32'h0);
      // Each divider code with its own channel, result read in both widths
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk_i);
         res <= 16'($random(seed));
         u_sadc_host_model.convert(2'(i), 2'(i));
         #1 compare({busy, hold}, 2'b11);
         n = 0;
         if (i == 2) begin
            q_bus.push_back(32'h0);
            u_sadc_host_model.read(1'b0); // Refused read while busy
            n = 2; // The refused read spends two clock edges
         end
         while (busy === 1'b1 && n < 400) begin
            @(posedge sys_clk_i);
            n++;
         end
         #1 compare(32'(n >= 2 * (NE << i) - 3 && n <= 2 * (NE << i) + 2),
                    32'h1);
         compare(32'(mux), 32'(4'h1 << i));
         q_bus.push_back({16'hFFFF, res});
         q_bus.push_back({16'h00FF, 8'h00, res[15:8]});
         u_sadc_host_model.read(1'b1);
         repeat (3) @(posedge sys_clk_i); // Gap before next strobe
      end
      // Status, result, sticky events and an unmapped address
      q_apb.push_back(32'h330);
      apb(1'b0, sadc_pkg::OFS_STATUS, 32'h0);
      q_apb.push_back({16'h0, res});
      apb(1'b0, sadc_pkg::OFS_RESULT, 32'h0);
      q_apb.push_back(32'h3);
      apb(1'b0, sadc_pkg::OFS_INT_STAT, 32'h0);
      q_apb.push_back(32'h0);
      apb(1'b0, 8'h20, 32'h0);
      compare({31'h0, err}, 32'h1);
      compare({31'h0, irq}, 32'h0);
      apb(1'b1, sadc_pkg::OFS_INT_MASK, 32'h3);
      #1 compare({31'h0, irq}, 32'h1);
      apb(1'b1, sadc_pkg::OFS_INT_STAT, 32'h3);
      #1 compare({31'h0, irq}, 32'h0);
      // Disabled block ignores the strobe
      apb(1'b1, sadc_pkg::OFS_CTRL, 32'h0);
      u_sadc_host_model.convert(2'h1, 2'h0);
      repeat (4) @(posedge sys_clk_i);
      #1 compare({31'h0, busy}, 32'h0);
      // Re-enabled block converts; the unmasked done event raises irq
      apb(1'b1, sadc_pkg::OFS_CTRL, 32'h1);
      u_sadc_host_model.convert(2'h2, 2'h0);
      repeat (2 * NE + 4) @(posedge sys_clk_i);
      #1 compare({30'h0, busy, irq}, 32'h1);
      compare(32'(mux), 32'h4);
      end_of_test();
   end
endmodule : sar_adc_parallel_host_interface_test
